// *** common/alert_bank_pkg.sv ***
// Constants for the threshold and overflow alert register bank.
// Assumes a 200 MHz system clock and byte-wide register access.
package alert_bank_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_VOLTAGE_TEMP     = 8'h81;
  localparam logic [7:0] ADDR_CURRENT_POWER    = 8'h82;
  localparam logic [7:0] ADDR_CHARGE           = 8'h83;
  localparam logic [7:0] ADDR_ENERGY           = 8'h84;
  localparam logic [7:0] ADDR_ACC_OVERFLOW     = 8'h85;
  localparam logic [7:0] ADDR_TIME             = 8'h86;
  localparam logic [7:0] ADDR_SUPPLY_OVERCUR   = 8'h87;
  localparam int         NUM_ALERT_REGS        = 7;
  localparam logic [7:0] ALERT_RESET_VALUE     = 8'h00;

  // ==========================================================================
  // Implemented bits per register; unlisted bits read as zero
  localparam logic [7:0] MASK_VOLTAGE_TEMP     = 8'hff;
  localparam logic [7:0] MASK_CURRENT_POWER    = 8'hff;
  localparam logic [7:0] MASK_CHARGE           = 8'h3f;
  localparam logic [7:0] MASK_ENERGY           = 8'hcf;
  localparam logic [7:0] MASK_ACC_OVERFLOW     = 8'hb7;
  localparam logic [7:0] MASK_TIME             = 8'hff;
  localparam logic [7:0] MASK_SUPPLY_OVERCUR   = 8'h0f;

  // ==========================================================================
  // Field positions
  localparam int BIT_OVERCURRENT_ONE = 2;
  localparam int BIT_OVERCURRENT_TWO = 3;
  localparam int TIME_OVF_BASE       = 4;

  // ==========================================================================
  // Accumulator guard levels, nominally 90 percent of full scale
  localparam logic [31:0] TIME_GUARD_LSB   = 32'd3865470565;
  localparam logic [47:0] ACCUM_GUARD_LSB  = 48'd126663739519794;

  // ==========================================================================
  // Persistence time before an alert is reported
  localparam longint PERSIST_TIME_MS  = 200;
  localparam longint CLOCK_HZ         = 200_000_000;
  localparam longint PERSIST_CYCLES   = (PERSIST_TIME_MS * CLOCK_HZ) / 1000;

endpackage : alert_bank_pkg

// *** verilog/alert_persist.sv ***
// One persistence filter per alert source: a condition must hold for
// HOLD_CYCLES consecutive cycles before the qualified output goes high; it stays high while the condition holds.
// Assumes conditions synchronous to sys_clk.
`timescale 1ns/1ps
module alert_persist import alert_bank_pkg::*; #(
  parameter int WIDTH       = 8,
  parameter int HOLD_CYCLES = 40_000_000,
  parameter int CNT_W       = 26
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] cond,
  output logic      [WIDTH-1:0] qualified
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_ch
      typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             hit;
      } persist_state_t;
      persist_state_t st_ff;
      persist_state_t nxt_st;

      always_comb begin
        nxt_st = st_ff;
        // Any drop of the condition restarts the count
        if (!cond[g]) begin
          nxt_st.count = '0;
          nxt_st.hit   = 1'b0;
        end else if (st_ff.count < CNT_W'(HOLD_CYCLES - 1)) begin
          nxt_st.count = st_ff.count + CNT_W'(1);
          nxt_st.hit   = 1'b0;
        end else begin
          nxt_st.hit   = 1'b1;
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          st_ff <= '0;
        end else begin
          st_ff <= nxt_st;
        end
      end

      // A condition present in the qualifying cycle still counts
      assign qualified[g] = st_ff.hit & cond[g];
    end
  endgenerate

endmodule : alert_persist

// *** verilog/threshold_overflow_alert_bank.sv ***
// Sticky threshold, overflow, supply and overcurrent alert registers.
// Assumes compare results arrive from the measurement datapath, the host
// reaches registers through a byte-wide read/write port, all inputs are
// synchronous to sys_clk.
`timescale 1ns/1ps
module threshold_overflow_alert_bank import alert_bank_pkg::*; #(
  parameter int PERSIST_HOLD = int'(PERSIST_CYCLES),
  parameter int PERSIST_W    = 26,
  parameter int HB_HALF      = 250
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Memory lock from the lock control register
  input  wire logic        memory_locked,
  // Threshold compare results from the datapath
  input  wire logic [7:0]  voltage_temp_cmp,
  input  wire logic [7:0]  current_power_cmp,
  input  wire logic [5:0]  charge_cmp,
  input  wire logic [7:0]  energy_cmp,
  input  wire logic [3:0]  time_threshold_cmp,
  input  wire logic [1:0]  supply_cmp,
  // Accumulator values for guard comparison
  input  wire logic [47:0] charge_acc_1,
  input  wire logic [47:0] charge_acc_2,
  input  wire logic [47:0] charge_acc_3,
  input  wire logic [47:0] energy_acc_1,
  input  wire logic [47:0] energy_acc_2,
  input  wire logic [47:0] energy_acc_4,
  input  wire logic [31:0] time_acc_1,
  input  wire logic [31:0] time_acc_2,
  input  wire logic [31:0] time_acc_3,
  input  wire logic [31:0] time_acc_4,
  // Deglitched overcurrent comparator outputs
  input  wire logic        overcurrent_comparator_one,
  input  wire logic        overcurrent_comparator_two,
  input  wire logic        heartbeat_enable,
  output logic             fifth_general_pin,
  output logic             overflow_alert
);

  // ==========================================================================
  // Guard comparisons
  function automatic logic over_guard48(input logic [47:0] v);
    logic [47:0] mag;
    mag = v[47] ? (~v + 48'h0000_0000_0001) : v;
    over_guard48 = (mag >= ACCUM_GUARD_LSB);
  endfunction : over_guard48

  logic [5:0] acc_ovf_raw;
  logic [3:0] time_ovf_raw;

  // Exact integer compares, both signs for 48-bit quantities
  assign acc_ovf_raw[0] = over_guard48(charge_acc_1);
  assign acc_ovf_raw[1] = over_guard48(charge_acc_2);
  assign acc_ovf_raw[2] = over_guard48(charge_acc_3);
  assign acc_ovf_raw[3] = over_guard48(energy_acc_1);
  assign acc_ovf_raw[4] = over_guard48(energy_acc_2);
  assign acc_ovf_raw[5] = over_guard48(energy_acc_4);
  assign time_ovf_raw[0] = (time_acc_1 >= TIME_GUARD_LSB);
  assign time_ovf_raw[1] = (time_acc_2 >= TIME_GUARD_LSB);
  assign time_ovf_raw[2] = (time_acc_3 >= TIME_GUARD_LSB);
  assign time_ovf_raw[3] = (time_acc_4 >= TIME_GUARD_LSB);

  // ==========================================================================
  // Bit placement of raw conditions into register images
  logic [7:0] raw_img [NUM_ALERT_REGS];
  always_comb begin
    raw_img[0] = voltage_temp_cmp;
    raw_img[1] = current_power_cmp;
    raw_img[2] = {2'b00, charge_cmp};
    raw_img[3] = {energy_cmp[7:6], 2'b00, energy_cmp[3:0]} & MASK_ENERGY;
    raw_img[4] = {acc_ovf_raw[5], 1'b0, acc_ovf_raw[4:3], 1'b0,
                  acc_ovf_raw[2:0]};
    raw_img[5] = {time_ovf_raw, time_threshold_cmp};
    raw_img[6] = {6'b00_0000, supply_cmp};
  end

  // ==========================================================================
  // Persistence filter on every slow alert source
  localparam int NRAW = NUM_ALERT_REGS * 8;
  logic [NRAW-1:0] raw_flat;
  logic [NRAW-1:0] qual_flat;

  genvar r;
  generate
    for (r = 0; r < NUM_ALERT_REGS; r++) begin : g_flat
      assign raw_flat[r*8 +: 8] = raw_img[r];
    end
  endgenerate

  alert_persist #(
    .WIDTH       (NRAW),
    .HOLD_CYCLES (PERSIST_HOLD),
    .CNT_W       (PERSIST_W)
  ) u_persist (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .cond      (raw_flat),
    .qualified (qual_flat)
  );

  // ==========================================================================
  // State
  typedef enum logic [2:0] {
    HB_RUN     = 3'b001,
    HB_STOPPED = 3'b010,
    HB_WAIT    = 3'b100
  } hb_state_t;

  typedef struct packed {
    logic [NUM_ALERT_REGS*8-1:0] alerts;
    logic [7:0]                  rdata;
    hb_state_t                   hb;
    logic [15:0]                 hb_cnt;
    logic                        hb_level;
  } bank_state_t;

  bank_state_t st_ff;
  bank_state_t nxt_st;

  logic [7:0] reg_mask [NUM_ALERT_REGS];
  assign reg_mask[0] = MASK_VOLTAGE_TEMP;
  assign reg_mask[1] = MASK_CURRENT_POWER;
  assign reg_mask[2] = MASK_CHARGE;
  assign reg_mask[3] = MASK_ENERGY;
  assign reg_mask[4] = MASK_ACC_OVERFLOW;
  assign reg_mask[5] = MASK_TIME;
  assign reg_mask[6] = MASK_SUPPLY_OVERCUR;

  logic       addr_hit;
  logic [2:0] addr_idx;
  logic [7:0] addr_off;
  assign addr_off = reg_addr - ADDR_VOLTAGE_TEMP;
  assign addr_hit = (reg_addr >= ADDR_VOLTAGE_TEMP) && (reg_addr <= ADDR_SUPPLY_OVERCUR);
  assign addr_idx = addr_off[2:0];

  logic [7:0] fast_set;
  logic       oc_pending;
  assign fast_set = {4'h0, overcurrent_comparator_two, overcurrent_comparator_one, 2'b00};
  assign oc_pending = st_ff.alerts[6*8 + BIT_OVERCURRENT_ONE]
                    | st_ff.alerts[6*8 + BIT_OVERCURRENT_TWO];

  always_comb begin
    logic [7:0] cur;
    logic [7:0] set_bits;
    cur      = '0;
    set_bits = '0;
    nxt_st   = st_ff;
    for (int i = 0; i < NUM_ALERT_REGS; i++) begin
      cur      = st_ff.alerts[i*8 +: 8];
      set_bits = qual_flat[i*8 +: 8];
      // Overcurrent bits bypass the slow filter
      if (i == NUM_ALERT_REGS - 1) begin
        set_bits = set_bits | fast_set;
      end
      if (reg_wr && addr_hit && (addr_idx == 3'(i))) begin
        cur = reg_wdata;
      end
      // Set wins over a same-cycle write; no hardware clear path exists
      nxt_st.alerts[i*8 +: 8] = (cur | set_bits) & reg_mask[i];
    end
    if (reg_rd) begin
      nxt_st.rdata = addr_hit ? st_ff.alerts[addr_idx*8 +: 8] : 8'h00;
    end
    // Heartbeat divider
    if (st_ff.hb_cnt == 16'(HB_HALF - 1)) begin
      nxt_st.hb_cnt = '0;
    end else begin
      nxt_st.hb_cnt = st_ff.hb_cnt + 16'h0001;
    end
    case (st_ff.hb)
      HB_RUN: begin
        if (st_ff.hb_cnt == 16'(HB_HALF - 1)) begin
          nxt_st.hb_level = ~st_ff.hb_level;
        end
        if (overcurrent_comparator_one || overcurrent_comparator_two || oc_pending) begin
          nxt_st.hb       = HB_STOPPED;
          nxt_st.hb_level = 1'b0;
        end
      end
      HB_STOPPED: begin
        nxt_st.hb_level = 1'b0;
        if (!oc_pending && !overcurrent_comparator_one && !overcurrent_comparator_two) begin
          nxt_st.hb = HB_WAIT;
        end
      end
      HB_WAIT: begin
        nxt_st.hb_level = 1'b0;
        if (oc_pending || overcurrent_comparator_one || overcurrent_comparator_two) begin
          nxt_st.hb = HB_STOPPED;
        end else if (!memory_locked) begin
          nxt_st.hb = HB_RUN;
        end
      end
      default: begin
        nxt_st.hb = HB_STOPPED;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff          <= '0;
      st_ff.hb       <= HB_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata         = st_ff.rdata;
  assign fifth_general_pin = heartbeat_enable & st_ff.hb_level;
  assign overflow_alert    = |st_ff.alerts[4*8 +: 8] | |st_ff.alerts[5*8 + TIME_OVF_BASE +: 4];

  // ==========================================================================
  // Assertions
  a_sticky_no_clear: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !(reg_wr && addr_hit) |=> ((st_ff.alerts & $past(st_ff.alerts)) == $past(st_ff.alerts)))
    else $error("alert bit cleared without write");

  a_write_loads: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && addr_hit && addr_idx == 3'd0 && voltage_temp_cmp == 8'h00)
    |=> ((st_ff.alerts[7:0] & ~$past(qual_flat[7:0])) == $past(reg_wdata)))
    else $error("write did not load value");

  a_set_beats_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && addr_hit && addr_idx == 3'd6 && overcurrent_comparator_one)
    |=> st_ff.alerts[6*8 + BIT_OVERCURRENT_ONE])
    else $error("overcurrent lost on write");

  a_fast_overcur: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    overcurrent_comparator_two |=> st_ff.alerts[6*8 + BIT_OVERCURRENT_TWO])
    else $error("overcurrent not flagged in one cycle");

  a_heartbeat_stop: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    overcurrent_comparator_one |=> ##1 (st_ff.hb == HB_STOPPED && !fifth_general_pin))
    else $error("heartbeat not stopped");

  a_heartbeat_resume: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_ff.hb == HB_WAIT && !memory_locked && !oc_pending
     && !overcurrent_comparator_one && !overcurrent_comparator_two)
    |=> st_ff.hb == HB_RUN)
    else $error("heartbeat did not resume");

  a_no_resume_locked: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_ff.hb != HB_RUN && memory_locked) |=> st_ff.hb != HB_RUN)
    else $error("heartbeat resumed under lock");

  a_persist_gate: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!supply_cmp[0] ##1 !st_ff.alerts[6*8] && !(reg_wr && addr_hit)) |=> !st_ff.alerts[6*8])
    else $error("supply alert set without persistence");

  a_time_guard: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    raw_flat[5*8 + TIME_OVF_BASE] == (time_acc_1 >= TIME_GUARD_LSB))
    else $error("time guard compare wrong");

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_ff.alerts[2*8 +: 8] & ~MASK_CHARGE) == 8'h00 && st_ff.alerts[4*8 + 3] == 1'b0)
    else $error("reserved bit set");

  a_unmapped_read_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && !addr_hit) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_unmapped_write_ignored: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && !addr_hit && fast_set == 8'h00 && qual_flat == '0)
    |=> st_ff.alerts == $past(st_ff.alerts))
    else $error("unmapped write changed alerts");

  a_time_read: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == ADDR_TIME)
    |=> reg_rdata == $past(st_ff.alerts[5*8 +: 8]))
    else $error("time register read wrong");

  a_energy_gap_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    st_ff.alerts[3*8 + 4 +: 2] == 2'b00)
    else $error("energy gap bits set");

  a_supply_upper_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    st_ff.alerts[6*8 + 4 +: 4] == 4'h0)
    else $error("supply upper bits set");

  a_overflow_bit_set: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    qual_flat[4*8 + 7] |=> st_ff.alerts[4*8 + 7])
    else $error("energy four overflow not flagged");

  a_time_overflow_set: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    qual_flat[5*8 + TIME_OVF_BASE] |=> st_ff.alerts[5*8 + TIME_OVF_BASE])
    else $error("time one overflow not flagged");

  a_guard_negative: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (charge_acc_2[47] && ((48'h0000_0000_0000 - charge_acc_2) >= ACCUM_GUARD_LSB))
    |-> raw_flat[4*8 + 1])
    else $error("negative guard crossing missed");

  a_overflow_output: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_ff.alerts[4*8 +: 8] != 8'h00) |-> overflow_alert)
    else $error("overflow alert output low");

  a_pin_toggles: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (st_ff.hb == HB_RUN && st_ff.hb_cnt == 16'(HB_HALF - 1) && !oc_pending
     && !overcurrent_comparator_one && !overcurrent_comparator_two)
    |=> st_ff.hb_level != $past(st_ff.hb_level))
    else $error("heartbeat did not toggle");

endmodule : threshold_overflow_alert_bank

// *** sim/host_register_master.sv ***
// Host model: byte register reads and writes, memory lock, alert release.
// Assumes the bank takes a request on the rising sys_clk edge.
`timescale 1ns/1ps
module host_register_master import alert_bank_pkg::*; (
  input  wire logic       sys_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  output logic            memory_locked
);
  initial begin
    reg_addr      = 8'h00;
    reg_wr        = 1'b0;
    reg_wdata     = 8'h00;
    reg_rd        = 1'b0;
    memory_locked = 1'b0;
  end

  // ====================
  // Bus cycles; afterwards the address, and after a write the data, carry the inverse so no stale value passes
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    data     = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~addr;
  endtask : read_reg

  task automatic set_lock(input logic on);
    @(posedge sys_clk);
    #1;
    memory_locked = on;
  endtask : set_lock

  // ====================
  // Re-read under lock, since events may arrive meanwhile
  task automatic clear_alerts();
    logic [7:0] d;
    for (int a = 0; a < NUM_ALERT_REGS; a++) begin
      read_reg(ADDR_VOLTAGE_TEMP + 8'(a), d); // Fresh read
      if (d !== 8'h00) write_reg(ADDR_VOLTAGE_TEMP + 8'(a), 8'h00); // Clear
    end
  endtask : clear_alerts

  task automatic release_alerts();
    set_lock(1'b1); // Lock before clearing
    clear_alerts();
    set_lock(1'b0); // Unlock last
  endtask : release_alerts
endmodule : host_register_master

// *** sim/threshold_overflow_alert_bank_tb_top.sv ***
// Self-checking bench for the sticky alert bank: access, persistence,
// guard compares, overcurrent heartbeat stop and release.
// Assumes the host model drives the register port and the memory lock.
`timescale 1ns/1ps
module threshold_overflow_alert_bank_tb_top import alert_bank_pkg::*;;
  // Short counts keep the run brief; all expectations use them
  localparam int HOLD = 8;
  localparam int HB   = 4;
  logic        sys_clk, reset_n, reg_wr, reg_rd, memory_locked, occ_one, occ_two, hb_en;
  logic        pin, ovf;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, vt_cmp, ip_cmp, en_cmp, d;
  logic [5:0]  ch_cmp;
  logic [3:0]  tt_cmp;
  logic [1:0]  sup_cmp;
  logic [47:0] c1, c2, c3, e1, e2, e4;
  logic [31:0] t1, t2, t3, t4;
  logic [7:0]  sv [7];
  int          error_cnt, tests_run;

  threshold_overflow_alert_bank #(.PERSIST_HOLD (HOLD), .HB_HALF (HB)) i_dut (
    .sys_clk (sys_clk), .reset_n (reset_n), .reg_addr (reg_addr), .reg_wr (reg_wr),
    .reg_wdata (reg_wdata), .reg_rd (reg_rd), .reg_rdata (reg_rdata),
    .memory_locked (memory_locked), .voltage_temp_cmp (vt_cmp), .current_power_cmp (ip_cmp),
    .charge_cmp (ch_cmp), .energy_cmp (en_cmp), .time_threshold_cmp (tt_cmp),
    .supply_cmp (sup_cmp), .charge_acc_1 (c1), .charge_acc_2 (c2), .charge_acc_3 (c3),
    .energy_acc_1 (e1), .energy_acc_2 (e2), .energy_acc_4 (e4), .time_acc_1 (t1),
    .time_acc_2 (t2), .time_acc_3 (t3), .time_acc_4 (t4),
    .overcurrent_comparator_one (occ_one), .overcurrent_comparator_two (occ_two),
    .heartbeat_enable (hb_en), .fifth_general_pin (pin), .overflow_alert (ovf)
  );

  host_register_master i_host (
    .sys_clk (sys_clk), .reg_addr (reg_addr), .reg_wr (reg_wr), .reg_wdata (reg_wdata),
    .reg_rd (reg_rd), .reg_rdata (reg_rdata), .memory_locked (memory_locked)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ====================
  // Expectations and checks
  function automatic logic [7:0] field_mask(input int k);
    logic [7:0] m [7];
    m = '{8'hff, 8'hff, 8'h3f, 8'hcf, 8'hb7, 8'hff, 8'h0f};
    return m[k];
  endfunction : field_mask

  function automatic logic [7:0] exp_slow(input int k);
    logic [7:0] m [7];
    m = '{8'hff, 8'hff, 8'h3f, 8'hcf, 8'h00, 8'h0f, 8'h03};
    return sv[k] & m[k];
  endfunction : exp_slow

  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got 0x%h exp 0x%h", $time, what, got, exp);
    end
  endtask : compare

  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    i_host.read_reg(addr, r);
    compare(r, exp, "register read");
  endtask : check_reg

  task automatic drive_slow(input logic on);
    vt_cmp  = on ? sv[0] : 8'h00;
    ip_cmp  = on ? sv[1] : 8'h00;
    ch_cmp  = on ? sv[2][5:0] : 6'h00;
    en_cmp  = on ? sv[3] : 8'h00;
    tt_cmp  = on ? sv[5][3:0] : 4'h0;
    sup_cmp = on ? sv[6][1:0] : 2'h0;
  endtask : drive_slow

  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (pin !== lvl && n < 2 * HB + 4) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    compare({7'h00, pin}, {7'h00, lvl}, "heartbeat level");
    if (pin !== lvl) end_sim();
  endtask : wait_pin

  task automatic hold_pin_low(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      compare({7'h00, pin}, 8'h00, "heartbeat stopped");
    end
  endtask : hold_pin_low

  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end

  // ====================
  // Main sequence
  initial begin
    reset_n   = 1'b0;
    hb_en     = 1'b1;
    occ_one   = 1'b0;
    occ_two   = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    {c1, c2, c3, e1, e2, e4} = '0;
    {t1, t2, t3, t4} = '0;
    sv = '{default: 8'h00};
    drive_slow(1'b0);
    void'($urandom(32'h0000_ccb6));
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    for (int a = 8'h80; a <= 8'h88; a++) check_reg(8'(a), 8'h00); // Reset
    i_host.write_reg(8'h88, 8'hff);
    check_reg(8'h88, 8'h00); // Unmapped write ignored
    for (int k = 0; k < 7; k++) begin
      d = 8'($urandom);
      i_host.write_reg(ADDR_VOLTAGE_TEMP + 8'(k), d);
      check_reg(ADDR_VOLTAGE_TEMP + 8'(k), d & field_mask(k));
    end
    i_host.release_alerts();
    repeat (4) begin
      for (int k = 0; k < 7; k++) sv[k] = 8'($urandom);
      drive_slow(1'b1);
      repeat (HOLD - 1) @(posedge sys_clk);
      #1;
      drive_slow(1'b0);
      for (int k = 0; k < 7; k++) check_reg(ADDR_VOLTAGE_TEMP + 8'(k), 8'h00);
      drive_slow(1'b1);
      repeat (HOLD + 2) @(posedge sys_clk);
      #1;
      drive_slow(1'b0);
      for (int k = 0; k < 7; k++) check_reg(ADDR_VOLTAGE_TEMP + 8'(k), exp_slow(k));
      compare({7'h00, ovf}, 8'h00, "no overflow alert");
      i_host.release_alerts();
    end
    // Guard levels at, just under and above the limit, both polarities for the 48-bit ones
    c1 = ACCUM_GUARD_LSB;
    c2 = -ACCUM_GUARD_LSB;
    c3 = ACCUM_GUARD_LSB - 48'h1;
    e1 = -(ACCUM_GUARD_LSB - 48'h1);
    e4 = ACCUM_GUARD_LSB + 48'h5;
    t1 = TIME_GUARD_LSB;
    t2 = TIME_GUARD_LSB - 32'h1;
    t3 = 32'hffff_ffff;
    repeat (HOLD + 2) @(posedge sys_clk);
    #1;
    {c1, c2, c3, e1, e4} = '0;
    {t1, t2, t3} = '0;
    check_reg(ADDR_ACC_OVERFLOW, 8'h83); // Charge/energy guard
    check_reg(ADDR_TIME, 8'h50); // Time guard
    compare({7'h00, ovf}, 8'h01, "overflow alert");
    i_host.release_alerts();
    wait_pin(1'b1); // Heartbeat running
    wait_pin(1'b0);
    hb_en = 1'b0;
    hold_pin_low(2 * HB + 2); // Gated pin stays low
    hb_en = 1'b1;
    fork
      i_host.write_reg(ADDR_SUPPLY_OVERCUR, 8'h00);
      begin
        @(posedge sys_clk);
        #1;
        occ_one = 1'b1;
      end
    join
    hold_pin_low(3 * HB); // Fast stop without filter
    occ_two = 1'b1;
    check_reg(ADDR_SUPPLY_OVERCUR, 8'h0c); // Set beats same-cycle write
    occ_one = 1'b0;
    occ_two = 1'b0;
    i_host.set_lock(1'b1); // Release order
    i_host.clear_alerts();
    hold_pin_low(2 * HB + 2); // Still stopped while locked
    i_host.set_lock(1'b0);
    wait_pin(1'b1); // Resumes after unlock
    // Mid-run reset must clear a loaded register and restart the heartbeat
    i_host.write_reg(ADDR_CHARGE, 8'h2a);
    reset_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    check_reg(ADDR_CHARGE, 8'h00);
    wait_pin(1'b1);
    end_sim();
  end
endmodule : threshold_overflow_alert_bank_tb_top
